/* design/spfl_boot_loader.sv */
/*
 * serial flash boot loader: reads the configuration image after reset
 * with the fast-read command, streams it out through a two-entry
 * buffer, then serves page-program requests.
 * assumes a 40 MHz clock, a mode 0 flash with pulled-up hold and
 * write-protect pins, and a consumer that drains the stream.
 */
// What this block does
// R1 - master, mode 0, one fixed clock rate
// R2 - addresses a 16-Mbit flash image
// R3 - after reset, read flash then initialise
// R4 - busy flag high during initialisation
// R5 - busy flag low when initialisation ends
// R6 - only fast read, no signature probing
// R7 - same serial clock for any flash
// R8 - one command reads consecutive bytes onward
// R9 - read is 0x0b, three address, one dummy
// R10 - flash writes use page-mode programming
// R11 - hold and write-protect pins not driven
// R12 - outputs change on serial clock fall
// R13 - input sampled on serial clock fall
// R14 - select low per command, clock idles low
`timescale 1ns/1ps
`default_nettype none
module spfl_boot_loader #(
    parameter int IMAGE_BYTES = spfl_pkg::FLASH_BYTES,
    parameter logic [23:0] IMAGE_BASE = 24'h000000
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // flash pins
    output logic flash_serial_clock,
    output logic flash_chip_select_n,
    output logic flash_data_out,
    input wire logic flash_data_in,
    // configuration stream
    output logic [7:0] cfg_data,
    output logic cfg_valid,
    input wire logic cfg_ready,
    // page program request
    input wire logic prog_start,
    input wire logic [spfl_pkg::ADDR_W-1:0] prog_addr,
    input wire logic [spfl_pkg::PAGE_LEN_W-1:0] prog_len,
    input wire logic [7:0] prog_data,
    input wire logic prog_valid,
    output logic prog_ready,
    output logic prog_busy,
    // status
    output logic init_busy_flag
);
    import spfl_pkg::*;

    // --------------------------------------------------------------
    // state
    // --------------------------------------------------------------
    localparam logic [23:0] RD_TOTAL = 24'(IMAGE_BYTES + HDR_RD_BYTES);
    // R7 fixed half period
    localparam logic [7:0] HALF_LAST = 8'(SCK_HALF_CYC - 1);
    localparam logic [7:0] CSH_LAST = 8'(CS_HIGH_CYC - 1);

    spfl_st_t state_reg, state_next;      // sequencer state
    spfl_seq_t seq_reg, seq_next;         // command in flight
    logic sck_reg, sck_next;              // serial clock level
    logic csn_reg, csn_next;              // chip select, low active
    logic mosi_reg, mosi_next;            // data to flash
    logic [7:0] tick_reg, tick_next;      // half period timer
    logic [2:0] bit_reg, bit_next;        // bit within byte
    logic gap_reg, gap_next;              // paused between bytes
    logic [7:0] tx_reg, tx_next;          // outgoing shift
    logic [7:0] rx_reg, rx_next;          // incoming shift
    logic [23:0] idx_reg, idx_next;       // byte within command
    logic [23:0] addr_reg, addr_next;     // page program address
    logic [23:0] total_reg, total_next;   // bytes in command
    logic [7:0] pend_reg, pend_next;      // program byte held
    logic pend_full_reg, pend_full_next;
    logic prdy_reg, prdy_next;            // hold register empty, as a flop
    logic pbusy_reg, pbusy_next;          // page program running
    logic busy_reg, busy_next;            // initialisation busy
    logic [7:0] d0_reg, d0_next, d1_reg, d1_next; // stream buffer
    logic v0_reg, v0_next, v1_reg, v1_next;
    logic din_s1_reg, din_s2_reg;         // input synchroniser

    // --------------------------------------------------------------
    // input synchroniser
    // --------------------------------------------------------------
    // two flops; only the second one is read by logic
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            din_s1_reg <= 1'b0;
            din_s2_reg <= 1'b0;
        end else begin
            din_s1_reg <= flash_data_in;
            din_s2_reg <= din_s1_reg;
        end
    end

    // --------------------------------------------------------------
    // byte source helpers
    // --------------------------------------------------------------
    // byte to send at a given index of the current command
    // R9 opcode, address, dummy order
    function automatic logic [7:0] byte_at(input spfl_seq_t sq,
            input logic [23:0] i, input logic [23:0] a,
            input logic [7:0] p);
        logic [7:0] b;
        b = DUMMY_BYTE;
        case (i)
            24'h000000: b = (sq == SQ_READ) ? OP_FAST_READ :
                            (sq == SQ_WEN) ? OP_WRITE_EN : OP_PAGE_PROG;
            24'h000001: b = a[23:16];
            24'h000002: b = a[15:8];
            24'h000003: b = a[7:0];
            default: b = (sq == SQ_PP) ? p : DUMMY_BYTE;
        endcase
        return b;
    endfunction

    // --------------------------------------------------------------
    // sequencer, shift engine and stream buffer
    // --------------------------------------------------------------
    always_comb begin
        logic push, pop, ok;
        logic [23:0] ni;
        push = 1'b0;
        pop = 1'b0;
        ok = 1'b0;
        ni = idx_reg + 24'h000001;
        state_next = state_reg;
        seq_next = seq_reg;
        sck_next = sck_reg;
        csn_next = csn_reg;
        mosi_next = mosi_reg;
        tick_next = tick_reg;
        bit_next = bit_reg;
        gap_next = gap_reg;
        tx_next = tx_reg;
        rx_next = rx_reg;
        idx_next = idx_reg;
        addr_next = addr_reg;
        total_next = total_reg;
        pend_next = pend_reg;
        pend_full_next = pend_full_reg;
        pbusy_next = pbusy_reg;
        busy_next = busy_reg;
        d0_next = d0_reg;
        d1_next = d1_reg;
        v0_next = v0_reg;
        v1_next = v1_reg;

        // program data holding register takes one byte at a time
        if (prog_valid && !pend_full_reg) begin
            pend_next = prog_data;
            pend_full_next = 1'b1;
        end

        // consumer pops the head slot
        pop = cfg_ready && v0_reg;

        case (state_reg)
            // R3 read after reset
            ST_BOOT: begin
                // R6 only fast read
                // R14 select falls, first bit valid
                seq_next = SQ_READ;
                total_next = RD_TOTAL;
                // R2 image base in flash
                addr_next = IMAGE_BASE;
                csn_next = 1'b0;
                idx_next = 24'h000000;
                bit_next = 3'd0;
                tick_next = 8'h00;
                gap_next = 1'b0;
                tx_next = OP_FAST_READ;
                mosi_next = OP_FAST_READ[7];
                state_next = ST_RUN;
            end
            ST_RUN: begin
                if (gap_reg) begin
                    // clock held low until the next byte can go
                    if (seq_reg == SQ_READ) begin
                        ok = !v1_reg || pop;
                    end else begin
                        ok = (seq_reg != SQ_PP) ||
                             (idx_reg < 24'(HDR_PP_BYTES)) ||
                             pend_full_reg;
                    end
                    if (ok) begin
                        tx_next = byte_at(seq_reg, idx_reg, addr_reg,
                                          pend_reg);
                        mosi_next = tx_next[7];
                        if (seq_reg == SQ_PP &&
                                idx_reg >= 24'(HDR_PP_BYTES)) begin
                            pend_full_next = 1'b0;
                        end
                        gap_next = 1'b0;
                        tick_next = 8'h00;
                    end
                end else if (tick_reg != HALF_LAST) begin
                    tick_next = tick_reg + 8'h01;
                end else if (!sck_reg) begin
                    // R1 fixed rate rising edge
                    sck_next = 1'b1;
                    tick_next = 8'h00;
                end else begin
                    // R12 outputs change on fall
                    sck_next = 1'b0;
                    tick_next = 8'h00;
                    // R13 sample on fall
                    rx_next = {rx_reg[6:0], din_s2_reg};
                    if (bit_reg != 3'd7) begin
                        bit_next = bit_reg + 3'd1;
                        tx_next = {tx_reg[6:0], 1'b0};
                        mosi_next = tx_reg[6];
                    end else begin
                        bit_next = 3'd0;
                        // R8 data bytes follow in address order
                        if (seq_reg == SQ_READ &&
                                idx_reg >= 24'(HDR_RD_BYTES)) begin
                            push = 1'b1;
                        end
                        // write enable is a single byte; total_reg keeps
                        // the page length plus header for the program that follows
                        if (ni == total_reg || seq_reg == SQ_WEN) begin
                            // R14 release select after last byte
                            csn_next = 1'b1;
                            state_next = ST_CSGAP;
                        end else begin
                            idx_next = ni;
                            gap_next = 1'b1;
                        end
                    end
                end
            end
            ST_CSGAP: begin
                // deselect time between commands
                if (tick_reg != CSH_LAST) begin
                    tick_next = tick_reg + 8'h01;
                end else if (seq_reg == SQ_WEN) begin
                    // R10 page program follows write enable
                    seq_next = SQ_PP;
                    csn_next = 1'b0;
                    idx_next = 24'h000000;
                    tick_next = 8'h00;
                    gap_next = 1'b1;
                    state_next = ST_RUN;
                end else begin
                    pbusy_next = 1'b0;
                    state_next = ST_IDLE;
                end
            end
            ST_IDLE: begin
                // R10 write request starts enable, then page
                if (prog_start && !pbusy_reg && !busy_reg &&
                        prog_len != '0) begin
                    seq_next = SQ_WEN;
                    addr_next = prog_addr;
                    total_next = 24'(prog_len) + 24'(HDR_PP_BYTES);
                    pbusy_next = 1'b1;
                    csn_next = 1'b0;
                    idx_next = 24'h000000;
                    tick_next = 8'h00;
                    gap_next = 1'b1;
                    state_next = ST_RUN;
                end
            end
            default: state_next = ST_IDLE;
        endcase

        // two-entry buffer: shift on pop, fill lowest free slot
        if (pop) begin
            d0_next = d1_reg;
            v0_next = v1_reg;
            v1_next = 1'b0;
        end
        if (push) begin
            if (!v0_next) begin
                d0_next = rx_next;
                v0_next = 1'b1;
            end else begin
                d1_next = rx_next;
                v1_next = 1'b1;
            end
        end

        // R4 busy until image read and drained
        // R5 then busy drops
        if (state_reg == ST_IDLE && !v0_reg && !v1_reg) begin
            busy_next = 1'b0;
        end

        // ready is registered from the hold register's next state, so it flips in the same cycle
        prdy_next = !pend_full_next;
    end

    // --------------------------------------------------------------
    // registers
    // --------------------------------------------------------------
    // clock idles low and select high from reset
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg <= ST_BOOT;
            seq_reg <= SQ_READ;
            sck_reg <= 1'b0;
            csn_reg <= 1'b1;
            mosi_reg <= 1'b0;
            tick_reg <= 8'h00;
            bit_reg <= 3'd0;
            gap_reg <= 1'b0;
            tx_reg <= 8'h00;
            rx_reg <= 8'h00;
            idx_reg <= 24'h000000;
            addr_reg <= 24'h000000;
            total_reg <= 24'h000000;
            pend_reg <= 8'h00;
            pend_full_reg <= 1'b0;
            prdy_reg <= 1'b1;
            pbusy_reg <= 1'b0;
            busy_reg <= 1'b1;
            d0_reg <= 8'h00;
            d1_reg <= 8'h00;
            v0_reg <= 1'b0;
            v1_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            seq_reg <= seq_next;
            sck_reg <= sck_next;
            csn_reg <= csn_next;
            mosi_reg <= mosi_next;
            tick_reg <= tick_next;
            bit_reg <= bit_next;
            gap_reg <= gap_next;
            tx_reg <= tx_next;
            rx_reg <= rx_next;
            idx_reg <= idx_next;
            addr_reg <= addr_next;
            total_reg <= total_next;
            pend_reg <= pend_next;
            pend_full_reg <= pend_full_next;
            prdy_reg <= prdy_next;
            pbusy_reg <= pbusy_next;
            busy_reg <= busy_next;
            d0_reg <= d0_next;
            d1_reg <= d1_next;
            v0_reg <= v0_next;
            v1_reg <= v1_next;
        end
    end

    // --------------------------------------------------------------
    // outputs, all straight from flops
    // --------------------------------------------------------------
    // R11 hold and write-protect have no port here
    assign flash_serial_clock = sck_reg;
    assign flash_chip_select_n = csn_reg;
    assign flash_data_out = mosi_reg;
    assign cfg_data = d0_reg;
    assign cfg_valid = v0_reg;
    assign prog_ready = prdy_reg;
    assign prog_busy = pbusy_reg;
    assign init_busy_flag = busy_reg;
endmodule
`default_nettype wire

/* common/spfl_pkg.sv */
/*
 * constants shared by the flash boot loader: opcodes, widths, timing.
 * assumes a 40 MHz system clock; all counts are derived from it here.
 */
package spfl_pkg;
    // --------------------------------------------------------------
    // system clock
    // --------------------------------------------------------------
    localparam int CLK_PERIOD_PS = 25000;     // 40 MHz
    // --------------------------------------------------------------
    // serial link timing
    // --------------------------------------------------------------
    localparam int SCK_RATE_KHZ = 33300;      // nominal serial clock
    // half period of the nominal serial clock in ps
    localparam int SCK_HALF_PS = 500000000 / SCK_RATE_KHZ;
    // least half period rounds up to whole system cycles
    localparam int SCK_HALF_RAW =
        (SCK_HALF_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    // the input synchroniser is two cycles deep, so a half period
    // below two would sample data the flash has just changed
    localparam int SCK_HALF_CYC = (SCK_HALF_RAW < 2) ? 2 : SCK_HALF_RAW;
    localparam int CS_HIGH_NS = 100;          // chip select high time
    localparam int CS_HIGH_CYC =
        (CS_HIGH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    // --------------------------------------------------------------
    // flash geometry
    // --------------------------------------------------------------
    localparam int FLASH_MBIT = 16;
    localparam int FLASH_BYTES = FLASH_MBIT * 1024 * 1024 / 8;
    localparam int ADDR_W = 24;               // three address bytes
    localparam int HDR_RD_BYTES = 5;          // op, 3 addr, 1 dummy
    localparam int HDR_PP_BYTES = 4;          // op, 3 addr
    localparam int PAGE_LEN_W = 9;            // up to 256 bytes a page
    // --------------------------------------------------------------
    // opcodes
    // --------------------------------------------------------------
    localparam logic [7:0] OP_FAST_READ = 8'h0b;
    localparam logic [7:0] OP_WRITE_EN = 8'h06;
    localparam logic [7:0] OP_PAGE_PROG = 8'h02;
    localparam logic [7:0] DUMMY_BYTE = 8'h00;
    // --------------------------------------------------------------
    // types
    // --------------------------------------------------------------
    typedef enum logic [1:0] {SQ_READ, SQ_WEN, SQ_PP} spfl_seq_t;
    typedef enum logic [1:0] {ST_BOOT, ST_RUN, ST_CSGAP, ST_IDLE} spfl_st_t;
endpackage

/* testbench/spfl_boot_loader_chk.sv */
/* checker for the flash boot loader: link timing, stream, status.
   assumes a bind onto spfl_boot_loader; sees its ports only. */
`timescale 1ns/1ps
`default_nettype none
module spfl_boot_loader_chk (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // flash pins
    input wire logic flash_serial_clock,
    input wire logic flash_chip_select_n,
    input wire logic flash_data_out,
    // stream and status
    input wire logic [7:0] cfg_data,
    input wire logic cfg_valid,
    input wire logic cfg_ready,
    input wire logic prog_start,
    input wire logic prog_busy,
    input wire logic init_busy_flag
);
    // ------------------------------------------------------------
    // link timing
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    // second high cycle, then the fall
    sequence sck_high_end;
        flash_serial_clock ##1 !flash_serial_clock;
    endsequence
    sck_high_two_a: assert property (
        $rose(flash_serial_clock) |-> ##1 sck_high_end)
        else $error("serial clock high phase not two cycles");
    sck_low_min_a: assert property (
        $fell(flash_serial_clock) |-> !flash_serial_clock [*2])
        else $error("serial clock low phase too short");
    idle_clock_low_a: assert property (
        flash_chip_select_n |-> !flash_serial_clock)
        else $error("serial clock not low while deselected");
    dout_on_low_a: assert property (
        $changed(flash_data_out) |-> !flash_serial_clock)
        else $error("data out moved while clock high");
    cs_on_low_a: assert property (
        $changed(flash_chip_select_n) |-> !flash_serial_clock)
        else $error("select moved while clock high");
    cs_gap_four_a: assert property (
        $rose(flash_chip_select_n) |-> flash_chip_select_n [*4])
        else $error("select high gap too short");
    // ------------------------------------------------------------
    // stream and status
    // ------------------------------------------------------------
    busy_during_boot_a: assert property (
        (cfg_valid || (!flash_chip_select_n && !prog_busy))
        |-> init_busy_flag)
        else $error("busy flag low during image load");
    busy_stays_low_a: assert property (
        !init_busy_flag |=> !init_busy_flag)
        else $error("busy flag rose again");
    cfg_hold_a: assert property (
        cfg_valid && !cfg_ready |=> cfg_valid && $stable(cfg_data))
        else $error("stalled byte lost or changed");
    prog_after_init_a: assert property (
        $rose(prog_busy) |-> $past(prog_start) && !$past(init_busy_flag))
        else $error("program started without request");
endmodule
bind spfl_boot_loader spfl_boot_loader_chk spfl_boot_loader_chk_i (
    .clk(clk), .reset_n(reset_n), .flash_serial_clock(flash_serial_clock),
    .flash_chip_select_n(flash_chip_select_n),
    .flash_data_out(flash_data_out), .cfg_data(cfg_data),
    .cfg_valid(cfg_valid), .cfg_ready(cfg_ready), .prog_start(prog_start),
    .prog_busy(prog_busy), .init_busy_flag(init_busy_flag));
`default_nettype wire

/* testbench/spfl_flash_model.sv */
/* behavioural serial flash: logs every byte, answers fast read.
   assumes mode 0 and a master that idles its clock low. */
`timescale 1ns/1ps
`default_nettype none
module spfl_flash_model (
    // flash pins, memory side
    input wire logic flash_serial_clock,
    input wire logic flash_chip_select_n,
    input wire logic flash_data_out,
    output logic flash_data_in
);
    logic [7:0] lg [0:255]; // every byte received
    int cs_at [0:15]; // log index where each command began
    int ln = 0;
    int cn = 0;
    int bitc = 0; // bits of the current frame
    logic [7:0] sh = 8'h00;
    logic [23:0] adr;
    logic [7:0] b;
    initial flash_data_in = 1'b0;
    // new frame: bit counter restarts, start index logged
    always @(negedge flash_chip_select_n) begin
        cs_at[cn] = ln;
        cn++;
        bitc = 0;
    end
    // bits taken on the rising edge
    always @(posedge flash_serial_clock) begin
        if (!flash_chip_select_n) begin
            sh = {sh[6:0], flash_data_out};
            bitc++;
            if (bitc % 8 == 0) begin
                lg[ln] = sh;
                ln++;
            end
        end
    end
    // answer after op, three address, one dummy
    always @(negedge flash_serial_clock or posedge flash_chip_select_n) begin
        if (!flash_chip_select_n && bitc >= 40 &&
                lg[cs_at[cn-1]] == 8'h0b) begin
            adr = {lg[cs_at[cn-1]+1], lg[cs_at[cn-1]+2], lg[cs_at[cn-1]+3]};
            adr = adr + 24'((bitc - 40) / 8);
            b = adr[7:0] ^ 8'ha5;
            flash_data_in <= #1 b[7 - (bitc - 40) % 8];
        end else begin
            // undriven line never keeps the last value
            flash_data_in <= #1 ~flash_data_in;
        end
    end
endmodule
`default_nettype wire

/* testbench/tb_spfl_boot_loader.sv */
/* self-checking bench: boot read with stalls, resets, page program.
   assumes spfl_flash_model on the pins and the bound checker. */
`timescale 1ns/1ps
`default_nettype none
module tb_spfl_boot_loader;
    typedef struct {int stall; logic [7:0] exp;} spfl_row_t;
    localparam int LIM = 3000;
    // stall before each take, byte stored at base plus row
    spfl_row_t rows [0:7] = '{'{0, 8'ha9}, '{0, 8'ha8}, '{5, 8'hab},
        '{0, 8'haa}, '{40, 8'hb5}, '{0, 8'hb4}, '{1, 8'hb7}, '{90, 8'hb6}};
    logic [7:0] pp [0:6] = '{8'h02, 8'h12, 8'h34, 8'h56,
        8'h11, 8'h22, 8'h33};
    logic clk = 1'b0;
    logic reset_n, sck, cs_n, dout, din, cfg_valid, cfg_ready;
    logic prog_start, prog_valid, prog_ready, prog_busy, init_busy_flag;
    logic [7:0] cfg_data, prog_data;
    logic [23:0] prog_addr;
    logic [8:0] prog_len;
    int failures = 0;
    int checks_done = 0;
    int n, base, s;
    always #12.5 clk = ~clk;
    spfl_boot_loader #(.IMAGE_BYTES(8), .IMAGE_BASE(24'h0a0b0c))
        spfl_boot_loader_i (
        .clk(clk), .reset_n(reset_n), .flash_serial_clock(sck),
        .flash_chip_select_n(cs_n), .flash_data_out(dout),
        .flash_data_in(din), .cfg_data(cfg_data), .cfg_valid(cfg_valid),
        .cfg_ready(cfg_ready), .prog_start(prog_start),
        .prog_addr(prog_addr), .prog_len(prog_len), .prog_data(prog_data),
        .prog_valid(prog_valid), .prog_ready(prog_ready),
        .prog_busy(prog_busy), .init_busy_flag(init_busy_flag));
    spfl_flash_model spfl_flash_model_i (.flash_serial_clock(sck),
        .flash_chip_select_n(cs_n), .flash_data_out(dout),
        .flash_data_in(din));
    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic report_and_stop();
        if (failures == 0 && checks_done > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    // a used-up wait counts as a failure and ends the run
    task automatic expire(input int cnt);
        if (cnt >= LIM) begin
            failures++;
            report_and_stop();
        end
    endtask
    // reset values of every output but cfg_data
    task automatic check_reset();
        check({sck, cs_n, dout, cfg_valid}, 4'b0100);
        check({prog_ready, prog_busy, init_busy_flag}, 3'b101);
    endtask
    // watchdog against any hang
    initial begin
        repeat (60000) @(posedge clk);
        failures++;
        report_and_stop();
    end
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        {reset_n, cfg_ready, prog_start, prog_valid} = 4'b0000;
        {prog_addr, prog_len, prog_data} = '0;
        repeat (6) @(negedge clk);
        check_reset();
        reset_n = 1'b1;
        repeat (3) @(negedge clk);
        check(cs_n, 1'b0);
        prog_start = 1'b1;
        prog_len = 9'h003;
        @(negedge clk);
        prog_start = 1'b0;
        @(negedge clk);
        check(prog_busy, 1'b0);
        repeat (100) @(negedge clk);
        reset_n = 1'b0;
        @(negedge clk);
        check_reset();
        repeat (5) @(negedge clk);
        base = spfl_flash_model_i.cn;
        reset_n = 1'b1;
        // image bytes, consumer stalling now and then
        for (int r = 0; r < 8; r++) begin
            repeat (rows[r].stall) @(negedge clk);
            for (n = 0; cfg_valid !== 1'b1 && n < LIM; n++) @(negedge clk);
            expire(n);
            check(cfg_data, rows[r].exp);
            if (r == 7) check(init_busy_flag, 1'b1);
            cfg_ready = 1'b1;
            @(negedge clk);
            cfg_ready = 1'b0;
            // let an edge pass before ready may rise again
            @(negedge clk);
        end
        for (n = 0; init_busy_flag !== 1'b0 && n < LIM; n++) @(negedge clk);
        expire(n);
        check({init_busy_flag, cfg_valid, cs_n, sck}, 4'b0010);
        s = spfl_flash_model_i.cs_at[base];
        check(spfl_flash_model_i.cn - base, 1);
        check(spfl_flash_model_i.lg[s], 8'h0b);
        check({spfl_flash_model_i.lg[s+1], spfl_flash_model_i.lg[s+2],
            spfl_flash_model_i.lg[s+3]}, 24'h0a0b0c);
        check(spfl_flash_model_i.ln - s, 13);
        // zero length is ignored, then a three byte page
        repeat (10) @(negedge clk);
        prog_len = 9'h000;
        prog_start = 1'b1;
        @(negedge clk);
        prog_start = 1'b0;
        @(negedge clk);
        check(prog_busy, 1'b0);
        prog_addr = 24'h123456;
        prog_len = 9'h003;
        prog_start = 1'b1;
        @(negedge clk);
        prog_start = 1'b0;
        for (int k = 0; k < 3; k++) begin
            repeat (k * 30) @(negedge clk);
            prog_data = pp[k+4];
            prog_valid = 1'b1;
            // ready seen high here is taken at the next rising edge
            for (n = 0; prog_ready !== 1'b1 && n < LIM; n++) @(negedge clk);
            expire(n);
            @(negedge clk);
            prog_valid = 1'b0;
        end
        for (n = 0; prog_busy !== 1'b0 && n < LIM; n++) @(negedge clk);
        expire(n);
        s = spfl_flash_model_i.cs_at[base+1];
        check(spfl_flash_model_i.lg[s], 8'h06);
        check(spfl_flash_model_i.cs_at[base+2] - s, 1);
        s = spfl_flash_model_i.cs_at[base+2];
        for (int k = 0; k < 7; k++) begin
            check(spfl_flash_model_i.lg[s+k], pp[k]);
        end
        check(spfl_flash_model_i.ln - s, 7);
        report_and_stop();
    end
endmodule
`default_nettype wire
